// [vaddr_seg_pkg.sv]
// shared types and constants for the segment and mode decoder
package vaddr_seg_pkg;
    localparam int unsigned VADDR_W = 32;
    localparam int unsigned PID_W = 6;
    localparam int unsigned SEG_HI_BIT = 31;
    localparam int unsigned SEG_MID_BIT = 30;
    localparam int unsigned SEG_LO_BIT = 29;
    localparam logic [31:0] DIRECT_MASK = 32'h1fffffff;
    localparam logic [31:0] FIXED_KMAP_BASE = 32'h00000000;
    localparam logic [31:0] FIXED_UMAP_OFFSET = 32'h40000000;
    localparam logic [31:0] BAD_VIRTUAL_ADDRESS_REG_RESET = 32'h00000000;
    // current level kernel, saved levels user: a restore after reset drops to user
    localparam logic [2:0] MODE_STACK_RESET = 3'h6;

    typedef enum logic [1:0] {
        user_segment,
        kernel_cached_direct_segment,
        kernel_uncached_direct_segment,
        kernel_mapped_segment
    } segment_t;

    typedef struct packed {
        logic valid;
        logic [31:0] vaddr;
    } access_req_t;

    typedef struct packed {
        logic valid;
        segment_t segment;
        logic mapped;
        logic cached;
        logic fixed;
        logic legal;
        logic [37:0] tlb_key;
        logic [31:0] paddr;
    } access_resp_t;
endpackage

// [vaddr_segment_mode_decoder.sv]
// privilege mode tracking and virtual address segment decoding
// Summary of operation
// [RL1] 4gB space splits into user-reachable low 2gB and kernel-only high 2gB.
// [RL2] Two modes, user and kernel; any exception forces kernel mode.
// [RL3] Kernel mode holds until restore-from-exception pops back the prior mode.
// [RL4] User mode sees only the single uniform 2gB user segment.
// [RL5] User-segment addresses are extended with a 6-bit process id before translation.
// [RL6] Kernel references to the user segment are treated like user references.
// [RL7] First 512mB kernel segment is cached, untranslated, mapped to physical low 0.5gB.
// [RL8] Second 512mB kernel segment is uncached, untranslated, same low 0.5gB.
// [RL9] Top 1gB kernel segment uses TLB cache bits, or fixed mapping fully cached.
// [RL10] Segment chosen from bit 31, then bits 30 and 29.
// [RL11] User reference to upper half raises address error and records address.
`timescale 1ns/1ps
module vaddr_segment_mode_decoder #(
    parameter bit HAS_TLB = 1'b1
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic exception_in,
    input wire logic restore_from_exception_instr_in,
    input wire logic [vaddr_seg_pkg::PID_W-1:0] pid_in,
    input wire vaddr_seg_pkg::access_req_t req_in,
    input wire logic tlb_cacheable_in,
    output vaddr_seg_pkg::access_resp_t resp_out,
    output logic kernel_mode_out,
    output logic addr_error_out,
    output logic [31:0] bad_virtual_address_reg_out
);
    // bit0 current, bit1 previous, bit2 old; 1 means user
    logic [2:0] mode_stack_reg;
    logic [2:0] mode_stack_next;
    logic kernel_mode_reg;
    vaddr_seg_pkg::access_resp_t resp_reg;
    vaddr_seg_pkg::access_resp_t resp_next;
    logic addr_error_reg;
    logic [31:0] bad_virtual_address_reg;
    logic user_now;
    logic illegal;

    assign user_now = mode_stack_reg[0];
    // user may only touch the low half; judged on the registered mode, so an exception in the same cycle does not mask it
    assign illegal = req_in.valid && user_now && req_in.vaddr[vaddr_seg_pkg::SEG_HI_BIT]; // RL1 RL4 RL11

    // exception wins when both strobes land in one cycle
    always_comb begin
        mode_stack_next = mode_stack_reg;
        if (exception_in) begin
            mode_stack_next = {mode_stack_reg[1:0], 1'b0}; // RL2
        end else if (restore_from_exception_instr_in) begin
            mode_stack_next = {mode_stack_reg[2], mode_stack_reg[2:1]}; // RL3
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mode_stack_reg <= vaddr_seg_pkg::MODE_STACK_RESET;
        end else begin
            mode_stack_reg <= mode_stack_next;
        end
    end

    // mode pin loaded from the same next value, so it never lags the stack
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            kernel_mode_reg <= !vaddr_seg_pkg::MODE_STACK_RESET[0];
        end else begin
            kernel_mode_reg <= !mode_stack_next[0]; // RL2 RL3
        end
    end

    always_comb begin
        resp_next = '0;
        resp_next.valid = req_in.valid;
        resp_next.legal = !illegal;
        resp_next.paddr = req_in.vaddr;
        resp_next.tlb_key = {pid_in, req_in.vaddr};
        if (!req_in.vaddr[vaddr_seg_pkg::SEG_HI_BIT]) begin // RL10
            // same treatment in both modes
            resp_next.segment = vaddr_seg_pkg::user_segment; // RL6
            resp_next.mapped = HAS_TLB;
            resp_next.fixed = !HAS_TLB;
            resp_next.cached = HAS_TLB ? tlb_cacheable_in : 1'b1;
            resp_next.tlb_key = {pid_in, req_in.vaddr}; // RL5
            if (!HAS_TLB) begin
                resp_next.paddr = req_in.vaddr + vaddr_seg_pkg::FIXED_UMAP_OFFSET;
            end
        end else begin
            case (req_in.vaddr[vaddr_seg_pkg::SEG_MID_BIT:vaddr_seg_pkg::SEG_LO_BIT])
                2'h0: begin
                    resp_next.segment = vaddr_seg_pkg::kernel_cached_direct_segment;
                    resp_next.cached = 1'b1; // RL7
                    resp_next.fixed = 1'b1;
                    resp_next.paddr = vaddr_seg_pkg::FIXED_KMAP_BASE
                        | (req_in.vaddr & vaddr_seg_pkg::DIRECT_MASK); // RL7
                end
                2'h1: begin
                    resp_next.segment = vaddr_seg_pkg::kernel_uncached_direct_segment;
                    resp_next.cached = 1'b0; // RL8
                    resp_next.fixed = 1'b1;
                    resp_next.paddr = vaddr_seg_pkg::FIXED_KMAP_BASE
                        | (req_in.vaddr & vaddr_seg_pkg::DIRECT_MASK); // RL8
                end
                default: begin
                    resp_next.segment = vaddr_seg_pkg::kernel_mapped_segment;
                    resp_next.mapped = HAS_TLB; // RL9
                    resp_next.fixed = !HAS_TLB;
                    resp_next.cached = HAS_TLB ? tlb_cacheable_in : 1'b1; // RL9
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            resp_reg <= '0;
        end else begin
            resp_reg <= resp_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            addr_error_reg <= 1'b0;
            bad_virtual_address_reg <= vaddr_seg_pkg::BAD_VIRTUAL_ADDRESS_REG_RESET;
        end else begin
            addr_error_reg <= illegal; // RL11
            if (illegal) begin
                bad_virtual_address_reg <= req_in.vaddr; // RL11
            end
        end
    end

    assign resp_out = resp_reg;
    assign kernel_mode_out = kernel_mode_reg;
    assign addr_error_out = addr_error_reg;
    assign bad_virtual_address_reg_out = bad_virtual_address_reg;

    a_exc_kernel: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        exception_in |=> kernel_mode_out) else $error("exception did not enter kernel"); // RL2
    a_kernel_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (kernel_mode_out && !restore_from_exception_instr_in) |=> kernel_mode_out)
        else $error("kernel mode left without restore"); // RL3
    a_restore_prior: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (restore_from_exception_instr_in && !exception_in)
        |=> mode_stack_reg[0] == $past(mode_stack_reg[1])) else $error("restore bad mode"); // RL3
    a_user_illegal: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.valid && !kernel_mode_out && req_in.vaddr[31])
        |=> addr_error_out && bad_virtual_address_reg_out == $past(req_in.vaddr))
        else $error("user upper-half access not flagged"); // RL11
    a_kernel_legal: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.valid && kernel_mode_out) |=> resp_out.legal) else $error("kernel access refused"); // RL1
    a_kseg_cached: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.vaddr[31:29] == 3'h4) |=> resp_out.cached && !resp_out.mapped
        && resp_out.paddr[31:29] == 3'h0) else $error("cached direct segment wrong"); // RL7
    a_kseg_uncached: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.vaddr[31:29] == 3'h5) |=> !resp_out.cached && !resp_out.mapped
        && resp_out.paddr[31:29] == 3'h0) else $error("uncached direct segment wrong"); // RL8
    a_kseg_mapped: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.vaddr[31:30] == 2'h3) |=> resp_out.segment
        == vaddr_seg_pkg::kernel_mapped_segment && resp_out.mapped == HAS_TLB)
        else $error("mapped segment wrong"); // RL9
    a_user_pid: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (!req_in.vaddr[31]) |=> resp_out.tlb_key == $past({pid_in, req_in.vaddr})
        && resp_out.segment == vaddr_seg_pkg::user_segment) else $error("pid key wrong"); // RL5

    // mode checks
    a_mode_matches_stack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        kernel_mode_out == !mode_stack_reg[0]) else $error("mode pin off stack"); // RL2

    a_restore_to_user: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (restore_from_exception_instr_in && !exception_in && mode_stack_reg[1])
        |=> !kernel_mode_out) else $error("restore did not return to user"); // RL3

    a_exc_push_stack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        exception_in |=> mode_stack_reg[2:1] == $past(mode_stack_reg[1:0]))
        else $error("exception did not save mode"); // RL2

    // legality and error capture
    a_user_low_legal: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.valid && !kernel_mode_out && !req_in.vaddr[31])
        |=> resp_out.legal && !addr_error_out) else $error("user low access refused"); // RL4

    a_user_high_refused: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.valid && !kernel_mode_out && req_in.vaddr[31])
        |=> !resp_out.legal) else $error("user upper access allowed"); // RL1

    a_no_false_error: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(req_in.valid && !kernel_mode_out && req_in.vaddr[31])
        |=> !addr_error_out) else $error("address error without cause"); // RL11

    a_bad_addr_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(req_in.valid && !kernel_mode_out && req_in.vaddr[31])
        |=> $stable(bad_virtual_address_reg_out)) else $error("bad address moved"); // RL11

    a_error_not_legal: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        addr_error_out |-> !resp_out.legal) else $error("error on legal access"); // RL11

    // segment decode
    a_user_seg_same: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (!req_in.vaddr[31]) |=> resp_out.mapped == HAS_TLB && resp_out.fixed != HAS_TLB)
        else $error("user segment treatment differs"); // RL6

    a_user_seg_cache: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (!req_in.vaddr[31]) |=> resp_out.cached == (HAS_TLB ? $past(tlb_cacheable_in) : 1'b1))
        else $error("user segment cache wrong"); // RL6

    a_direct_fixed: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.vaddr[31:30] == 2'h2) |=> resp_out.fixed && !resp_out.mapped)
        else $error("direct segment translated"); // RL10

    a_direct_paddr: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.vaddr[31:30] == 2'h2)
        |=> resp_out.paddr == ($past(req_in.vaddr) & vaddr_seg_pkg::DIRECT_MASK))
        else $error("direct segment address wrong"); // RL7

    a_kmap_cache: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (req_in.vaddr[31:30] == 2'h3)
        |=> resp_out.cached == (HAS_TLB ? $past(tlb_cacheable_in) : 1'b1))
        else $error("mapped segment cache wrong"); // RL9

    a_valid_echo: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        1'b1 |=> resp_out.valid == $past(req_in.valid)) else $error("valid not echoed"); // RL10
endmodule

// [tlb_entry_model.sv]
// far-side model of the translation buffer supplying the entry cache bit
`timescale 1ns/1ps
module tlb_entry_model (
    input wire vaddr_seg_pkg::access_req_t req_in,
    output logic cacheable_out
);
    // cache bit is the inverse of address bit 4 so both values show up
    assign cacheable_out = ~req_in.vaddr[4];
endmodule

// [testbench.sv]
// self-checking bench for the segment and mode decoder
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic exc = 1'b0;
    logic restore_from_exception_instr = 1'b0;
    logic [5:0] pid = 6'h2a;
    logic tlb_c;
    logic kmode;
    logic aerr;
    logic [31:0] bad;
    vaddr_seg_pkg::access_req_t req = '0;
    vaddr_seg_pkg::access_resp_t resp;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    vaddr_segment_mode_decoder vaddr_segment_mode_decoder_i (.sys_clk_in(sys_clk),
        .rst_n_in(rst_n), .exception_in(exc), .restore_from_exception_instr_in(restore_from_exception_instr),
        .pid_in(pid), .req_in(req), .tlb_cacheable_in(tlb_c), .resp_out(resp),
        .kernel_mode_out(kmode), .addr_error_out(aerr), .bad_virtual_address_reg_out(bad));
    tlb_entry_model tlb_entry_model_i (.req_in(req), .cacheable_out(tlb_c));
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(string what, logic [37:0] exp, logic [37:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic seg_case(logic [31:0] a, logic [1:0] s, logic m, logic c, logic [31:0] p);
        @(posedge sys_clk);
        req <= '{valid: 1'b1, vaddr: a};
        @(posedge sys_clk);
        #1;
        chk("segment", s, resp.segment);
        chk("mapped", m, resp.mapped);
        chk("cached", c, resp.cached);
        chk("fixed", !m, resp.fixed);
        chk("paddr", p, resp.paddr);
        chk("legal", 1'b1, resp.legal);
        chk("key", {pid, a}, resp.tlb_key);
        chk("error", 1'b0, aerr);
    endtask
    task automatic mode_case(logic e, logic r);
        @(posedge sys_clk);
        exc <= e;
        restore_from_exception_instr <= r;
        @(posedge sys_clk);
        exc <= 1'b0;
        restore_from_exception_instr <= 1'b0;
        #1;
        chk("kernel", 1'b1, kmode);
    endtask
    task automatic user_case();
        @(posedge sys_clk);
        restore_from_exception_instr <= 1'b1;
        @(posedge sys_clk);
        restore_from_exception_instr <= 1'b0;
        req <= '{valid: 1'b1, vaddr: 32'h80000040};
        #1;
        chk("kernel", 1'b0, kmode);
        @(posedge sys_clk);
        #1;
        chk("legal", 1'b0, resp.legal);
        chk("error", 1'b1, aerr);
        chk("bad", 32'h80000040, bad);
        @(posedge sys_clk);
        req <= '{valid: 1'b1, vaddr: 32'h00000100};
        @(posedge sys_clk);
        #1;
        chk("legal", 1'b1, resp.legal);
        chk("error", 1'b0, aerr);
        chk("segment", 2'h0, resp.segment);
        chk("key", {pid, 32'h00000100}, resp.tlb_key);
    endtask
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("kernel", 1'b1, kmode);
        chk("bad", 32'h0, bad);
        // kernel mode reaches all four segments, user segment as in user mode
        seg_case(32'h12345670, 2'h0, 1'b1, 1'b0, 32'h12345670);
        seg_case(32'h7fffffe0, 2'h0, 1'b1, 1'b1, 32'h7fffffe0);
        seg_case(32'h80001234, 2'h1, 1'b0, 1'b1, 32'h00001234);
        seg_case(32'h9fffffff, 2'h1, 1'b0, 1'b1, 32'h1fffffff);
        seg_case(32'ha0001000, 2'h2, 1'b0, 1'b0, 32'h00001000);
        seg_case(32'hbfffffe0, 2'h2, 1'b0, 1'b0, 32'h1fffffe0);
        seg_case(32'hc0000010, 2'h3, 1'b1, 1'b0, 32'hc0000010);
        seg_case(32'hffffffe0, 2'h3, 1'b1, 1'b1, 32'hffffffe0);
        user_case();
        mode_case(1'b1, 1'b0);
        mode_case(1'b1, 1'b1);
        mode_case(1'b0, 1'b1);
        chk("bad", 32'h80000040, bad);
        close_out();
    end
endmodule
